// >>> src/aofp_core.sv
// converter back end: output format, output bus, power mode, clock divider
// assumes samples arrive in offset binary, one per sys_clk, and that all pins are synchronous
//
// Local design decisions: the Wishbone slave port and the address map.
`default_nettype none

module aofp_core #(
    parameter int unsigned WIDTH         = aofp_pkg::SAMPLE_W,
    parameter int unsigned LATENCY       = aofp_pkg::PIPE_LATENCY,
    parameter int unsigned RELOCK_CYCLES = aofp_pkg::RELOCK_CYCLES
) (
    input  wire logic                        sys_clk,
    input  wire logic                        reset,
    // wishbone slave
    input  wire logic                        wb_cyc_i,
    input  wire logic                        wb_stb_i,
    input  wire logic                        wb_we_i,
    input  wire logic [aofp_pkg::ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]                  wb_sel_i,
    input  wire logic [31:0]                 wb_dat_i,
    output logic [31:0]                      wb_dat_o,
    output logic                             wb_ack_o,
    // converter core side
    input  wire logic [WIDTH-1:0]            sample_offset,
    input  wire logic                        sample_overrange,
    input  wire logic                        clock_halt_seen,
    // strap and control pins
    input  wire aofp_pkg::aofp_tri_pin_t     power_mode_select_pin,
    input  wire aofp_pkg::aofp_tri_pin_t     divide_ratio_pin,
    input  wire logic                        divider_sync_reset_pos,
    input  wire logic                        divider_sync_reset_neg,
    // output bus and driver controls
    output aofp_pkg::aofp_out_bus_t          out_bus,
    output logic                             cmos_mode,
    output logic                             ddr_mode,
    output logic                             drive_reduced,
    output logic                             sample_strobe
);

    // ------------------------------------------------------------------
    // register state
    // ------------------------------------------------------------------
    logic [7:0]                 cfg;
    logic [2:0]                 pwr_ovr;
    logic [2:0]                 div_ovr;
    aofp_pkg::aofp_power_t      power_state;
    aofp_pkg::aofp_div_t        div_sel;
    logic [1:0]                 div_cnt;
    logic                       div1_toggle;
    logic                       sync_req_d;
    logic                       synced;
    logic [3:0]                 sync_wait;
    logic                       clock_lost;
    logic [$clog2(RELOCK_CYCLES+1)-1:0] relock_cnt;
    logic [WIDTH-1:0]           held_word;
    logic                       held_ovr;
    logic [WIDTH:0]             pipe [LATENCY];

    logic                       bus_req;
    logic                       sync_edge;
    logic                       sample_en;
    logic                       clk_level;
    logic                       outputs_on;
    logic [WIDTH-1:0]           coded;
    aofp_pkg::aofp_power_t      next_power;
    aofp_pkg::aofp_div_t        next_div;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
                                              input logic en);
        merge_byte = en ? new_v : old_v;
    endfunction : merge_byte

    function automatic logic [1:0] div_last(input aofp_pkg::aofp_div_t d);
        case (d)
            aofp_pkg::AOFP_DIV_2: div_last = 2'h1;
            aofp_pkg::AOFP_DIV_4: div_last = 2'h3;
            default:              div_last = 2'h0;
        endcase
    endfunction : div_last

    // ------------------------------------------------------------------
    // wishbone slave
    // ------------------------------------------------------------------
    assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            wb_ack_o <= 1'b0;
        else
            wb_ack_o <= bus_req;
    end

    // writes take effect on the same edge as the ack, one cycle after the request
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cfg     <= aofp_pkg::CFG_RESET;
            pwr_ovr <= 3'h0;
            div_ovr <= 3'h0;
        end
        else if (bus_req && wb_we_i)
        begin
            case (wb_adr_i)
                aofp_pkg::REG_CFG: cfg <= merge_byte(cfg, wb_dat_i[7:0], wb_sel_i[0]);
                aofp_pkg::REG_PWR: pwr_ovr <= wb_sel_i[0] ? wb_dat_i[2:0] : pwr_ovr;
                aofp_pkg::REG_DIV: div_ovr <= wb_sel_i[0] ? wb_dat_i[2:0] : div_ovr;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            wb_dat_o <= 32'h0000_0000;
        else if (bus_req && !wb_we_i)
        begin
            case (wb_adr_i)
                aofp_pkg::REG_CFG:    wb_dat_o <= {24'h00_0000, cfg};
                aofp_pkg::REG_PWR:    wb_dat_o <= {29'h0000_0000, pwr_ovr};
                aofp_pkg::REG_DIV:    wb_dat_o <= {29'h0000_0000, div_ovr};
                aofp_pkg::REG_STATUS: wb_dat_o <= {25'h000_0000, outputs_on, (relock_cnt != '0), synced,
                                                   div_sel, power_state};
                default:              wb_dat_o <= 32'h0000_0000;
            endcase
        end
        else
            wb_dat_o <= 32'h0000_0000;
    end

    // ------------------------------------------------------------------
    // power mode
    // ------------------------------------------------------------------
    always_comb
    begin
        if (pwr_ovr[aofp_pkg::OVR_EN_BIT])
            next_power = aofp_pkg::aofp_power_t'(pwr_ovr[2:1]);
        else if (power_mode_select_pin.floating)
            next_power = aofp_pkg::AOFP_PWR_SLEEP;
        else if (power_mode_select_pin.level)
            next_power = aofp_pkg::AOFP_PWR_NAP;
        else
            next_power = aofp_pkg::AOFP_PWR_NORMAL;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            power_state <= aofp_pkg::AOFP_PWR_SLEEP;
        else
        begin
            case (next_power)
                aofp_pkg::AOFP_PWR_NORMAL: power_state <= aofp_pkg::AOFP_PWR_NORMAL;
                aofp_pkg::AOFP_PWR_NAP:    power_state <= aofp_pkg::AOFP_PWR_NAP;
                aofp_pkg::AOFP_PWR_SLEEP:  power_state <= aofp_pkg::AOFP_PWR_SLEEP;
                default:                   power_state <= aofp_pkg::AOFP_PWR_SLEEP;
            endcase
        end
    end

    // a halted clock during nap is remembered so that the wake-up waits for the loop
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            clock_lost <= 1'b0;
            relock_cnt <= '0;
        end
        else if (power_state == aofp_pkg::AOFP_PWR_NAP)
        begin
            if (clock_halt_seen)
                clock_lost <= 1'b1;
            relock_cnt <= '0;
        end
        else if (power_state == aofp_pkg::AOFP_PWR_NORMAL && clock_lost)
        begin
            clock_lost <= 1'b0;
            relock_cnt <= ($clog2(RELOCK_CYCLES+1))'(RELOCK_CYCLES);
        end
        else if (relock_cnt != '0)
            relock_cnt <= relock_cnt - 1'b1;
    end

    // a pending relock keeps the drivers off in the cycle before the count loads
    assign outputs_on = (power_state == aofp_pkg::AOFP_PWR_NORMAL) && (relock_cnt == '0) && !clock_lost;

    // ------------------------------------------------------------------
    // clock divider
    // ------------------------------------------------------------------
    always_comb
    begin
        if (div_ovr[aofp_pkg::OVR_EN_BIT])
            next_div = aofp_pkg::aofp_div_t'(div_ovr[2:1]);
        else if (divide_ratio_pin.floating)
            next_div = aofp_pkg::AOFP_DIV_1;
        else if (divide_ratio_pin.level)
            next_div = aofp_pkg::AOFP_DIV_4;
        else
            next_div = aofp_pkg::AOFP_DIV_2;
    end

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            div_sel <= aofp_pkg::AOFP_DIV_1;
        else if (next_div == aofp_pkg::AOFP_DIV_4)
            div_sel <= aofp_pkg::AOFP_DIV_4;
        else if (next_div == aofp_pkg::AOFP_DIV_2)
            div_sel <= aofp_pkg::AOFP_DIV_2;
        else
            div_sel <= aofp_pkg::AOFP_DIV_1;
    end

    // only the pair in its asserted state counts; a non-complementary pair is no request
    assign sync_edge = divider_sync_reset_pos & ~divider_sync_reset_neg & ~sync_req_d;

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            sync_req_d <= 1'b0;
        else
            sync_req_d <= divider_sync_reset_pos & ~divider_sync_reset_neg;
    end

    // the phase after reset is arbitrary as seen from outside until a sync edge arrives
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            div_cnt <= 2'h0;
        else if (sync_edge && div_sel != aofp_pkg::AOFP_DIV_1)
            div_cnt <= 2'h0;
        else if (div_cnt >= div_last(div_sel))
            div_cnt <= 2'h0;
        else
            div_cnt <= div_cnt + 2'h1;
    end

    assign sample_en = (div_cnt >= div_last(div_sel));

    always_ff @(posedge sys_clk)
    begin
        if (reset)
            div1_toggle <= 1'b0;
        else if (sample_en)
            div1_toggle <= ~div1_toggle;
    end

    // at divide by 2 and 4 the output clock is high for the first half of each sample period; at divide by 1 it toggles on every sample
    always_comb
    begin
        case (div_sel)
            aofp_pkg::AOFP_DIV_2: clk_level = (div_cnt == 2'h0);
            aofp_pkg::AOFP_DIV_4: clk_level = (div_cnt < 2'h2);
            default:              clk_level = div1_toggle;
        endcase
    end

    // sync status rises once the aligned sample has crossed the whole pipeline
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            synced    <= 1'b0;
            sync_wait <= 4'h0;
        end
        else if (sync_edge && div_sel != aofp_pkg::AOFP_DIV_1)
        begin
            synced    <= 1'b0;
            sync_wait <= 4'(LATENCY);
        end
        else if (sample_en && sync_wait != 4'h0)
        begin
            sync_wait <= sync_wait - 4'h1;
            synced    <= (sync_wait == 4'h1);
        end
    end

    // ------------------------------------------------------------------
    // sample pipeline and encoding
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            for (int i = 0; i < LATENCY; i++)
                pipe[i] <= '0;
        end
        else if (sample_en)
        begin
            pipe[0] <= {sample_overrange, sample_offset};
            for (int i = 1; i < LATENCY; i++)
                pipe[i] <= pipe[i-1];
        end
    end

    aofp_encoder #(
        .WIDTH       (WIDTH)
    ) u_encoder (
        .offset_word (pipe[LATENCY-1][WIDTH-1:0]),
        .format      (aofp_pkg::aofp_format_t'(cfg[aofp_pkg::CFG_FMT_LSB +: 2])),
        .coded_word  (coded)
    );

    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            held_word <= '0;
            held_ovr  <= 1'b0;
        end
        else if (sample_en)
        begin
            held_word <= coded;
            held_ovr  <= pipe[LATENCY-1][WIDTH];
        end
    end

    // ------------------------------------------------------------------
    // output bus
    // ------------------------------------------------------------------
    // in double rate the upper half rides the high clock phase and the lower half the low one
    always_ff @(posedge sys_clk)
    begin
        if (reset)
            out_bus <= '0;
        else
        begin
            if (cfg[aofp_pkg::CFG_DDR_BIT])
                out_bus.data <= {{(WIDTH-aofp_pkg::HALF_W){1'b0}},
                                 clk_level ? held_word[WIDTH-1 -: aofp_pkg::HALF_W]
                                           : held_word[aofp_pkg::HALF_W-1:0]};
            else
                out_bus.data <= held_word;
            out_bus.overrange           <= held_ovr;
            out_bus.forwarded_clock_pos <= clk_level;
            out_bus.forwarded_clock_neg <= ~clk_level;
            out_bus.data_oe             <= outputs_on;
            out_bus.overrange_oe        <= outputs_on;
            out_bus.forwarded_clock_oe  <= outputs_on;
        end
    end

    // driver controls: reduced drive has meaning only for the differential drivers
    always_ff @(posedge sys_clk)
    begin
        if (reset)
        begin
            cmos_mode     <= 1'b0;
            ddr_mode      <= 1'b0;
            drive_reduced <= 1'b0;
            sample_strobe <= 1'b0;
        end
        else
        begin
            cmos_mode     <= cfg[aofp_pkg::CFG_CMOS_BIT];
            ddr_mode      <= cfg[aofp_pkg::CFG_DDR_BIT];
            drive_reduced <= cfg[aofp_pkg::CFG_LOWDRV_BIT] & ~cfg[aofp_pkg::CFG_CMOS_BIT];
            sample_strobe <= sample_en;
        end
    end

endmodule : aofp_core

`default_nettype wire

// >>> src/aofp_pkg.sv
// package for the converter output format and power control block
// assumes a single 100 MHz device clock and a classic wishbone register bus
`default_nettype none

package aofp_pkg;

    // ------------------------------------------------------------------
    // widths and register map
    // ------------------------------------------------------------------
    localparam int unsigned SAMPLE_W   = 14;
    localparam int unsigned HALF_W     = 7;
    localparam int unsigned ADR_W      = 8;
    localparam logic [7:0]  REG_CFG    = 8'h00;
    localparam logic [7:0]  REG_PWR    = 8'h04;
    localparam logic [7:0]  REG_DIV    = 8'h08;
    localparam logic [7:0]  REG_STATUS = 8'h0c;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned CFG_CMOS_BIT   = 0;
    localparam int unsigned CFG_DDR_BIT    = 1;
    localparam int unsigned CFG_LOWDRV_BIT = 2;
    localparam int unsigned CFG_FMT_LSB    = 4;
    localparam int unsigned OVR_EN_BIT     = 0;
    localparam int unsigned OVR_VAL_LSB    = 1;

    // ------------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        AOFP_FMT_OFFSET = 2'b00,
        AOFP_FMT_TWOS   = 2'b01,
        AOFP_FMT_GRAY   = 2'b10
    } aofp_format_t;

    typedef enum logic [1:0] {
        AOFP_PWR_NORMAL = 2'b00,
        AOFP_PWR_NAP    = 2'b01,
        AOFP_PWR_SLEEP  = 2'b10
    } aofp_power_t;

    typedef enum logic [1:0] {
        AOFP_DIV_1 = 2'b00,
        AOFP_DIV_2 = 2'b01,
        AOFP_DIV_4 = 2'b10
    } aofp_div_t;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic floating;
        logic level;
    } aofp_tri_pin_t;

    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic                data_oe;
        logic                overrange;
        logic                overrange_oe;
        logic                forwarded_clock_pos;
        logic                forwarded_clock_neg;
        logic                forwarded_clock_oe;
    } aofp_out_bus_t;

    // ------------------------------------------------------------------
    // reset values, timing
    // ------------------------------------------------------------------
    localparam logic [7:0]  CFG_RESET       = 8'h10;
    localparam int unsigned PIPE_LATENCY    = 8;
    localparam int unsigned CLK_PERIOD_NS   = 10;
    localparam int unsigned DLL_RELOCK_NS   = 52000;
    localparam int unsigned RELOCK_CYCLES   = (DLL_RELOCK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : aofp_pkg

`default_nettype wire

// >>> src/aofp_encoder.sv
// sample encoder: offset binary in, selected output code out
// assumes the format select is stable for the sample being encoded
`default_nettype none

module aofp_encoder #(
    parameter int unsigned WIDTH = aofp_pkg::SAMPLE_W
) (
    input  wire logic [WIDTH-1:0]         offset_word,
    input  wire aofp_pkg::aofp_format_t   format,
    output logic [WIDTH-1:0]              coded_word
);

    // ------------------------------------------------------------------
    // code functions
    // ------------------------------------------------------------------
    function automatic logic [WIDTH-1:0] to_gray(input logic [WIDTH-1:0] b);
        to_gray = b ^ (b >> 1);
    endfunction : to_gray

    function automatic logic [WIDTH-1:0] to_twos(input logic [WIDTH-1:0] b);
        to_twos = {~b[WIDTH-1], b[WIDTH-2:0]};
    endfunction : to_twos

    always_comb
    begin
        case (format)
            aofp_pkg::AOFP_FMT_OFFSET: coded_word = offset_word;
            aofp_pkg::AOFP_FMT_TWOS:   coded_word = to_twos(offset_word);
            aofp_pkg::AOFP_FMT_GRAY:   coded_word = to_gray(offset_word);
            default:                   coded_word = to_twos(offset_word);
        endcase
    end

endmodule : aofp_encoder

`default_nettype wire

// >>> dv/aofp_core_assertions.sv
// checker for the converter output block, ports only
// assumes one sys_clk domain and a synchronous reset
`default_nettype none
module aofp_core_assertions (
    input wire logic                    sys_clk,
    input wire logic                    reset,
    input wire logic                    wb_cyc_i,
    input wire logic                    wb_stb_i,
    input wire logic [31:0]             wb_dat_o,
    input wire logic                    wb_ack_o,
    input wire aofp_pkg::aofp_out_bus_t out_bus,
    input wire logic                    cmos_mode,
    input wire logic                    ddr_mode,
    input wire logic                    drive_reduced
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);
    AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("no ack after request");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    AST_OE_GROUP: assert property (out_bus.data_oe == out_bus.forwarded_clock_oe
        && out_bus.data_oe == out_bus.overrange_oe) else $error("output enables differ");
    AST_CLK_DIFF: assert property (out_bus.forwarded_clock_oe
        |-> out_bus.forwarded_clock_neg != out_bus.forwarded_clock_pos) else $error("clock pair not complementary");
    AST_CMOS_DRIVE: assert property (cmos_mode |-> !drive_reduced)
        else $error("reduced drive in cmos");
    AST_RESET_QUIET: assert property (disable iff (1'b0) reset |=> !wb_ack_o && !out_bus.data_oe)
        else $error("outputs active in reset");
    // data register loads from the same cfg bit on the same edge as the mode; the check still looks two back
    AST_DDR_UPPER: assert property (ddr_mode && $past(ddr_mode, 2) && out_bus.data_oe
        |-> out_bus.data[13:7] == 7'h00) else $error("ddr upper lines not idle");
endmodule : aofp_core_assertions
bind aofp_core aofp_core_assertions u_chk (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .out_bus(out_bus),
    .cmos_mode(cmos_mode), .ddr_mode(ddr_mode), .drive_reduced(drive_reduced));
`default_nettype wire

// >>> dv/aofp_rx_model.sv
// capture receiver model at the far side of the output bus
// assumes it shares sys_clk with the block
`default_nettype none
module aofp_rx_model (
    input  wire logic                     sys_clk,
    input  wire logic                     sync_req,
    input  wire aofp_pkg::aofp_out_bus_t  out_bus,
    output logic                          sync_pos,
    output logic                          sync_neg,
    output logic [aofp_pkg::SAMPLE_W-1:0] decoded
);
    timeunit 1ns;
    timeprecision 1ps;
    // pair moves just after the edge, so it is steady around the next one
    always_ff @(posedge sys_clk)
    begin
        sync_pos <= sync_req;
        sync_neg <= !sync_req;
    end
    // gray back to offset binary: needs the decoded higher bit, msb first
    always_comb
    begin
        decoded[13] = out_bus.data[13];
        for (int i = 12; i >= 0; i--)
        begin
            decoded[i] = out_bus.data[i] ^ decoded[i+1];
        end
    end
endmodule : aofp_rx_model
`default_nettype wire

// >>> dv/tb_top.sv
// testbench for the converter output block
// assumes one 100 MHz clock; far side is aofp_rx_model
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [13:0] ob;
        logic [13:0] tc;
        logic [13:0] gy;
    } aofp_row_t;
    localparam aofp_row_t ROWS [5] = '{'{14'h0000, 14'h2000, 14'h0000}, '{14'h0001, 14'h2001, 14'h0001},
        '{14'h2000, 14'h0000, 14'h3000}, '{14'h3ffe, 14'h1ffe, 14'h2001}, '{14'h3fff, 14'h1fff, 14'h2000}};
    localparam logic [1:0] PINS [3] = '{2'h2, 2'h1, 2'h0};
    localparam logic [1:0] DPIN [5] = '{2'h2, 2'h0, 2'h1, 2'h2, 2'h0};
    localparam logic [2:0] DREG [5] = '{3'h0, 3'h0, 3'h0, 3'h3, 3'h5};
    localparam int         DCNT [5] = '{40, 20, 10, 20, 10};
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [31:0] wb_dat_i = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [13:0] sample_offset = 14'h0000;
    logic clock_halt_seen = 1'b0;
    aofp_pkg::aofp_tri_pin_t power_mode_select_pin = 2'h0;
    aofp_pkg::aofp_tri_pin_t divide_ratio_pin = 2'h2;
    logic sync_req = 1'b0;
    logic sync_pos;
    logic sync_neg;
    logic [13:0] decoded;
    aofp_pkg::aofp_out_bus_t out_bus;
    logic cmos_mode;
    logic ddr_mode;
    logic drive_reduced;
    logic sample_strobe;
    logic ph;
    int cnt;
    int num_errors = 0;
    int comparisons = 0;
    always #5 sys_clk = ~sys_clk;
    aofp_core #(.LATENCY(3), .RELOCK_CYCLES(20)) dut (.sys_clk(sys_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sample_offset(sample_offset), .sample_overrange(sample_offset[13]),
        .clock_halt_seen(clock_halt_seen), .power_mode_select_pin(power_mode_select_pin),
        .divide_ratio_pin(divide_ratio_pin), .divider_sync_reset_pos(sync_pos), .divider_sync_reset_neg(sync_neg),
        .out_bus(out_bus), .cmos_mode(cmos_mode), .ddr_mode(ddr_mode), .drive_reduced(drive_reduced),
        .sample_strobe(sample_strobe));
    aofp_rx_model rx (.sys_clk(sys_clk), .sync_req(sync_req), .out_bus(out_bus), .sync_pos(sync_pos),
        .sync_neg(sync_neg), .decoded(decoded));
    task automatic test_done();
        if (num_errors == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    // request held until ack is sampled high at an edge
    task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] rd);
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask : wb_cycle
    task automatic wb_wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] rd;
        wb_cycle(1'b1, adr, dat, rd);
    endtask : wb_wr
    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] rd;
        wb_cycle(1'b0, adr, 32'h0000_0000, rd);
        check(rd, exp);
    endtask : rd_chk
    task automatic do_reset();
        reset <= 1'b1;
        repeat (8) @(posedge sys_clk);
        reset <= 1'b0;
    endtask : do_reset
    task automatic sync_pulse();
        @(posedge sys_clk);
        sync_req <= 1'b1;
        @(posedge sys_clk);
        sync_req <= 1'b0;
    endtask : sync_pulse
    // watchdog: the whole sequence needs well under 2000 cycles
    initial
    begin
        #100us;
        num_errors++;
        test_done();
    end
    initial
    begin
        do_reset();
        foreach (ROWS[i])
        begin
            for (int f = 0; f < 3; f++)
            begin
                wb_wr(aofp_pkg::REG_CFG, 32'(f) << aofp_pkg::CFG_FMT_LSB);
                sample_offset <= ROWS[i].ob;
                repeat (12) @(posedge sys_clk);
                check(out_bus.data, f == 0 ? ROWS[i].ob : f == 1 ? ROWS[i].tc : ROWS[i].gy);
            end
            check(decoded, ROWS[i].ob);
            check(out_bus.overrange, ROWS[i].ob[13]);
        end
        // second reset in mid-run, then register defaults
        do_reset();
        rd_chk(aofp_pkg::REG_CFG, 32'h0000_0010);
        rd_chk(aofp_pkg::REG_PWR, 32'h0000_0000);
        rd_chk(aofp_pkg::REG_DIV, 32'h0000_0000);
        wb_wr(8'h20, 32'h0000_00ff);
        rd_chk(8'h20, 32'h0000_0000);
        sync_pulse();
        repeat (20) @(posedge sys_clk);
        rd_chk(aofp_pkg::REG_STATUS, 32'h0000_0040);
        wb_wr(aofp_pkg::REG_CFG, 32'h0000_0017);
        repeat (2) @(posedge sys_clk);
        check({cmos_mode, ddr_mode, drive_reduced}, 3'h6);
        wb_wr(aofp_pkg::REG_CFG, 32'h0000_0016);
        repeat (2) @(posedge sys_clk);
        check({cmos_mode, ddr_mode, drive_reduced}, 3'h3);
        wb_wr(aofp_pkg::REG_CFG, 32'h0000_0010);
        foreach (PINS[i])
        begin
            power_mode_select_pin <= PINS[i];
            repeat (4) @(posedge sys_clk);
            check(out_bus.data_oe, 32'(i == 2));
        end
        power_mode_select_pin <= 2'h1;
        wb_wr(aofp_pkg::REG_PWR, 32'h0000_0001);
        repeat (3) @(posedge sys_clk);
        check(out_bus.data_oe, 1'b1);
        power_mode_select_pin <= 2'h0;
        wb_wr(aofp_pkg::REG_PWR, 32'h0000_0005);
        repeat (3) @(posedge sys_clk);
        check(out_bus.data_oe, 1'b0);
        // clock lost during nap: wake must wait for relock
        wb_wr(aofp_pkg::REG_PWR, 32'h0000_0003);
        clock_halt_seen <= 1'b1;
        repeat (4) @(posedge sys_clk);
        clock_halt_seen <= 1'b0;
        wb_wr(aofp_pkg::REG_PWR, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        check(out_bus.data_oe, 1'b0);
        repeat (8) @(posedge sys_clk);
        check(out_bus.data_oe, 1'b0);
        repeat (20) @(posedge sys_clk);
        check(out_bus.data_oe, 1'b1);
        foreach (DPIN[i])
        begin
            divide_ratio_pin <= DPIN[i];
            wb_wr(aofp_pkg::REG_DIV, 32'(DREG[i]));
            repeat (4) @(posedge sys_clk);
            cnt = 0;
            repeat (40)
            begin
                @(posedge sys_clk);
                cnt += int'(sample_strobe === 1'b1);
            end
            check(32'(cnt), 32'(DCNT[i]));
        end
        // odd spacing between the two syncs: only a real realign keeps the phase
        wb_wr(aofp_pkg::REG_DIV, 32'h0000_0000);
        sync_pulse();
        repeat (9) @(posedge sys_clk);
        ph = out_bus.forwarded_clock_pos;
        repeat (4) @(posedge sys_clk);
        sync_pulse();
        repeat (9) @(posedge sys_clk);
        check(out_bus.forwarded_clock_pos, ph);
        repeat (20) @(posedge sys_clk);
        rd_chk(aofp_pkg::REG_STATUS, 32'h0000_0054);
        test_done();
    end
endmodule : tb_top
`default_nettype wire
